/* File: hdl/swb_pkg.sv */
package swb_pkg;
  // opcode patterns of the three operand forms
  localparam logic [7:0] SWB_OP_IMM      = 8'h94;
  localparam logic [6:0] SWB_OP_IND_HI   = 7'h4b;  // 1001_011r
  localparam logic [4:0] SWB_OP_REG_HI   = 5'h13;  // 1001_1rrr
  // flags register bit positions
  localparam int SWB_FLAG_BORROW = 7;
  localparam int SWB_FLAG_HALF   = 6;
  localparam int SWB_FLAG_USER0  = 5;
  localparam int SWB_FLAG_BANKH  = 4;
  localparam int SWB_FLAG_BANKL  = 3;
  localparam int SWB_FLAG_RANGE  = 2;
  localparam int SWB_FLAG_USER1  = 1;
  localparam int SWB_FLAG_PARITY = 0;
  // reset values
  localparam logic [7:0] SWB_ACC_RESET   = 8'h00;
  localparam logic [7:0] SWB_FLAGS_RESET = 8'h00;
  localparam logic [2:0] SWB_SEL_RESET   = 3'h0;
  localparam logic [7:0] SWB_ADDR_RESET  = 8'h00;
  localparam logic       SWB_DONE_RESET  = 1'b0;
  localparam logic [1:0] SWB_LEN_RESET   = 2'h0;
  // instruction lengths in bytes
  localparam logic [1:0] SWB_LEN_IMM = 2'h2;
  localparam logic [1:0] SWB_LEN_ONE = 2'h1;

  typedef enum logic [1:0] {
    SWB_FORM_NONE = 2'h0,
    SWB_FORM_IMM  = 2'h1,
    SWB_FORM_IND  = 2'h3,
    SWB_FORM_REG  = 2'h2
  } swb_form_type;
endpackage

/* File: hdl/swb_unit.sv */
`timescale 1ns/1ps
// What this block does
// - immediate form subtracts borrow plus second byte; two bytes, one cycle.
// - indirect form reads memory at address held in register 0 or 1.
// - indirect form is one byte, one cycle, no operand bytes fetched.
// - register form subtracts borrow plus register chosen by low three opcode bits.
// - difference goes back to accumulator and flags update in same instruction.
// - only borrow, half-borrow, signed-range and parity flags change.
module swb_unit
  import swb_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       issue,         // one-cycle pulse: opcode valid
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] imm_byte,      // second instruction byte
  input  wire logic [7:0] reg_rdata,     // register file answer for the register the current opcode names
  input  wire logic [7:0] mem_rdata,     // data memory answer at the pointer held in the register the current opcode names
  output logic      [2:0] reg_sel,
  output logic      [7:0] mem_addr,
  output logic      [7:0] acc,
  output logic      [7:0] flags_register,
  output logic            done,
  output logic      [1:0] instr_len
);

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
    logic [2:0] reg_sel;
    logic [7:0] mem_addr;
    logic       done;
    logic [1:0] len;
  } swb_state_type;

  swb_state_type cur;
  swb_state_type next_cur;

  // classify the opcode
  function automatic swb_form_type swb_decode(input logic [7:0] op);
    if (op == SWB_OP_IMM)
      return SWB_FORM_IMM;
    else if (op[7:1] == SWB_OP_IND_HI)
      return SWB_FORM_IND;
    else if (op[7:3] == SWB_OP_REG_HI)
      return SWB_FORM_REG;
    else
      return SWB_FORM_NONE;
  endfunction

  // even-parity bit: set when the byte holds an odd number of ones
  function automatic logic swb_parity(input logic [7:0] v);
    return ^v;
  endfunction

  // subtrahend for each form; unknown forms feed zero so nothing toggles
  function automatic logic [7:0] swb_select_operand(input swb_form_type f,
                                                     input logic [7:0]   imm,
                                                     input logic [7:0]   mem,
                                                     input logic [7:0]   regv);
    case (f)
      SWB_FORM_IMM: return imm;
      SWB_FORM_IND: return mem;
      SWB_FORM_REG: return regv;
      default:      return 8'h00;
    endcase
  endfunction

  // register index handed to the register file for each form
  function automatic logic [2:0] swb_reg_index(input swb_form_type f,
                                                input logic [7:0]   op);
    if (f == SWB_FORM_IND)
      return {2'h0, op[0]};
    else
      return op[2:0];
  endfunction

  // byte count of an executed instruction; only the immediate form has a second byte
  function automatic logic [1:0] swb_length(input swb_form_type f);
    if (f == SWB_FORM_IMM)
      return SWB_LEN_IMM;
    else
      return SWB_LEN_ONE;
  endfunction

  // signed overflow of a - b: unlike operand signs and a result sign that left a
  function automatic logic swb_overflow(input logic a_sign,
                                        input logic b_sign,
                                        input logic r_sign);
    return (a_sign ^ b_sign) & (a_sign ^ r_sign);
  endfunction

  // assemble the flags byte from its named bits
  function automatic logic [7:0] swb_pack_flags(input logic borrow,
                                                 input logic half,
                                                 input logic user0,
                                                 input logic bank_high,
                                                 input logic bank_low,
                                                 input logic range,
                                                 input logic user1,
                                                 input logic parity);
    logic [7:0] f;
    f                  = 8'h00;
    f[SWB_FLAG_BORROW] = borrow;
    f[SWB_FLAG_HALF]   = half;
    f[SWB_FLAG_USER0]  = user0;
    f[SWB_FLAG_BANKH]  = bank_high;
    f[SWB_FLAG_BANKL]  = bank_low;
    f[SWB_FLAG_RANGE]  = range;
    f[SWB_FLAG_USER1]  = user1;
    f[SWB_FLAG_PARITY] = parity;
    return f;
  endfunction

  // decode and operand path
  swb_form_type form;
  logic         executes;
  logic [7:0]   operand;
  logic         cin;

  // arithmetic path
  logic [8:0]   diff;
  logic [4:0]   low_diff;

  // flag candidates, applied only when an instruction executes
  logic         borrow_out;
  logic         half_borrow_flag;
  logic         signed_range_flag;
  logic         parity_out;

  // status bits this unit never changes
  logic         user_flag_zero;
  logic         user_flag_one;
  logic         bank_select_high;
  logic         bank_select_low;

  // classify the opcode and pick the subtrahend; register and memory reads
  // are combinational, so the whole instruction finishes on the issuing edge
  // limitation: reg_rdata and mem_rdata must settle within one clock
  always_comb begin
    form     = swb_decode(opcode);
    executes = issue && (form != SWB_FORM_NONE);  // unknown opcodes are ignored
    cin      = cur.flags[SWB_FLAG_BORROW];
    operand  = swb_select_operand(form, imm_byte, mem_rdata, reg_rdata);
  end

  // nine-bit and five-bit differences expose the borrows out of bits 7 and 3
  always_comb begin
    diff     = {1'b0, cur.acc} - {1'b0, operand} - {8'h00, cin};
    low_diff = {1'b0, cur.acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, cin};
  end

  // flag candidates; the borrow in joins both differences, so a chain of
  // byte subtractions sees one consistent borrow
  always_comb begin
    borrow_out        = diff[8];
    half_borrow_flag  = low_diff[4];
    signed_range_flag = swb_overflow(cur.acc[7], operand[7], diff[7]);
    parity_out        = swb_parity(diff[7:0]);
  end

  // held bits ride through every instruction unchanged;
  // there is no write port for them in this unit
  always_comb begin
    user_flag_zero   = cur.flags[SWB_FLAG_USER0];
    user_flag_one    = cur.flags[SWB_FLAG_USER1];
    bank_select_high = cur.flags[SWB_FLAG_BANKH];
    bank_select_low  = cur.flags[SWB_FLAG_BANKL];
  end

  // next state; every field starts from its current value, so idle and
  // refused cycles leave accumulator and flags untouched
  always_comb begin
    next_cur      = cur;
    next_cur.done = 1'b0;
    // register select tracks the opcode every cycle
    next_cur.reg_sel  = swb_reg_index(form, opcode);
    // indirect pointer: partner returns register 0/1 contents on reg_rdata
    next_cur.mem_addr = reg_rdata;
    // executing cycle: result, flags and length land together
    if (executes) begin
      next_cur.acc   = diff[7:0];
      next_cur.done  = 1'b1;
      // only the listed flags take new values
      next_cur.flags = swb_pack_flags(borrow_out,
                                      half_borrow_flag,
                                      user_flag_zero,
                                      bank_select_high,
                                      bank_select_low,
                                      signed_range_flag,
                                      user_flag_one,
                                      parity_out);
      // one byte for indirect and register forms, two for immediate
      next_cur.len   = swb_length(form);
    end
  end

  // state register; synchronous reset, so each field takes a constant
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur.acc      <= SWB_ACC_RESET;
      cur.flags    <= SWB_FLAGS_RESET;
      cur.reg_sel  <= SWB_SEL_RESET;
      cur.mem_addr <= SWB_ADDR_RESET;
      cur.done     <= SWB_DONE_RESET;
      cur.len      <= SWB_LEN_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs come straight from the state register, none is combinational,
  // so the core never sees a glitch from the operand path
  assign acc            = cur.acc;
  assign flags_register = cur.flags;
  assign reg_sel        = cur.reg_sel;
  assign mem_addr       = cur.mem_addr;
  assign done           = cur.done;
  assign instr_len      = cur.len;

endmodule // swb_unit

/* File: testbench/swb_chk.sv */
`timescale 1ns/1ps
module swb_chk
  import swb_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       issue,
  input wire logic       done,
  input wire logic [1:0] instr_len,
  input wire logic [7:0] opcode,
  input wire logic [7:0] imm_byte,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] acc,
  input wire logic [7:0] flags_register
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // form decode from the opcode pattern
  wire c  = flags_register[7];
  wire im = issue && opcode == SWB_OP_IMM;
  wire ir = issue && opcode[7:1] == SWB_OP_IND_HI;
  wire rg = issue && opcode[7:3] == SWB_OP_REG_HI;
  chk_imm_diff: assert property (im |=> acc == $past(acc - imm_byte - c)) else $error("imm");
  chk_ind_diff: assert property (ir |=> acc == $past(acc - mem_rdata - c)) else $error("ind");
  chk_reg_diff: assert property (rg |=> acc == $past(acc - reg_rdata - c)) else $error("reg");
  chk_one_byte: assert property (ir || rg |=> instr_len == SWB_LEN_ONE && done)
    else $error("one byte form");
  chk_two_byte: assert property (im |=> instr_len == SWB_LEN_IMM && done)
    else $error("two byte form");
  chk_refused_op: assert property (!(im || ir || rg) |=> !done && $stable(acc))
    else $error("stray update");
  chk_user_bits: assert property ($stable({flags_register[5:3], flags_register[1]}))
    else $error("user bits moved");
  chk_parity_bit: assert property (done |-> flags_register[0] == ^acc) else $error("parity");
  cover property (im);
  cover property (ir);
  cover property (rg ##1 rg);
endmodule // swb_chk
bind swb_unit swb_chk u_chk (.mclk(mclk), .rst(rst), .issue(issue), .done(done),
  .instr_len(instr_len), .opcode(opcode), .imm_byte(imm_byte), .reg_rdata(reg_rdata),
  .mem_rdata(mem_rdata), .acc(acc), .flags_register(flags_register));

/* File: testbench/swb_partner.sv */
`timescale 1ns/1ps
module swb_partner (
  input  wire logic       issue,
  input  wire logic [7:0] opcode,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] mem_rdata
);
  logic [7:0] regs [8];
  logic [7:0] mem  [256];
  logic [2:0] sel;
  // indirect form points at r0/r1; idle cycles show inverted data so stale values fail
  assign sel       = opcode[3] ? opcode[2:0] : {2'h0, opcode[0]};
  assign reg_rdata = issue ? regs[sel] : ~regs[sel];
  assign mem_rdata = issue ? mem[regs[sel]] : ~mem[regs[sel]];
endmodule // swb_partner

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import swb_pkg::*;
  logic       mclk = 0, rst = 1, issue = 0, done, hit;
  logic [1:0] instr_len;
  logic [2:0] reg_sel, e_sel;
  logic [7:0] opcode = 0, imm_byte = 0, reg_rdata, mem_rdata, acc, flags_register, v;
  logic [7:0] mem_addr, e_ptr, p;
  logic [7:0] m_acc = 0, m_fl = 0;
  int         error_cnt = 0, checks_done = 0, d, c, s, m_len = 0;
  always #25 mclk = ~mclk;
  swb_unit u_dut (.mclk(mclk), .rst(rst), .issue(issue), .opcode(opcode), .imm_byte(imm_byte),
    .reg_rdata(reg_rdata), .mem_rdata(mem_rdata), .reg_sel(reg_sel),
    .mem_addr(mem_addr), .acc(acc),
    .flags_register(flags_register), .done(done), .instr_len(instr_len));
  swb_partner u_prt (.issue(issue), .opcode(opcode), .reg_rdata(reg_rdata), .mem_rdata(mem_rdata));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp || $isunknown(got)) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // random forms, idle cycles and a refused opcode, mostly back to back
  initial begin
    void'($urandom(25));
    // every register and memory byte known before the first issue
    for (int k = 0; k < 256; k++) begin
      u_prt.mem[k] = 8'($urandom);
      u_prt.regs[k % 8] = 8'($urandom);
    end
    repeat (10) @(negedge mclk);
    rst = 0;
    // a second reset over two edges in mid-run checks the reset values again
    for (int i = 0; i < 600; i++) begin
      rst = i == 300 || i == 301;
      u_prt.regs[i % 8] = 8'($urandom);
      d = $urandom % 12;
      issue = $urandom % 5 != 0;
      imm_byte = 8'($urandom);
      opcode = d < 8 ? 8'h98 + 8'(d) : d == 8 ? SWB_OP_IMM : d < 11 ? 8'h8d + 8'(d) : 8'h95;
      v = d == 8 ? imm_byte : d < 8 ? u_prt.regs[d] : u_prt.mem[u_prt.regs[d - 9]];
      hit = issue && d < 11 && !rst;
      p = u_prt.regs[opcode[3] ? opcode[2:0] : {2'h0, opcode[0]}];
      e_sel = rst ? 3'h0 : (d == 9 || d == 10) ? {2'h0, opcode[0]} : opcode[2:0];
      e_ptr = rst ? 8'h00 : issue ? p : ~p;
      @(negedge mclk);
      if (rst) begin
        m_acc = 0;
        m_fl = 0;
        m_len = 0;
      end else if (hit) begin
        c = m_fl[7];
        s = $signed(m_acc) - $signed(v) - c;
        m_fl[7] = m_acc < v + c;
        m_fl[6] = m_acc[3:0] < v[3:0] + c;
        m_fl[2] = s > 127 || s < -128;
        m_acc = 8'(m_acc - v - c);
        m_fl[0] = ^m_acc;
        m_len = d == 8 ? 2 : 1;
      end
      cmp(acc, m_acc);
      cmp(flags_register, m_fl);
      cmp({7'h0, done}, {7'h0, hit});
      cmp({6'h0, instr_len}, 8'(m_len));
      cmp({5'h0, reg_sel}, {5'h0, e_sel});
      cmp(mem_addr, e_ptr);
    end
    end_of_test();
  end
endmodule // testbench
